//--- rtl/gpio_pkg.sv
// Package with register map, field positions and reset values of the dual port block.
`default_nettype none
package gpio_pkg;
	// ==========================================
	// Register offsets
	localparam logic [3:0] ADDR_FIRST_DATA = 4'h0;
	localparam logic [3:0] ADDR_SECOND_DATA = 4'h1;
	localparam logic [3:0] ADDR_FIRST_DIRECTION = 4'h4;
	localparam logic [3:0] ADDR_SECOND_DIRECTION = 4'h5;
	localparam logic [3:0] ADDR_FIRST_PULLUP = 4'h8;
	localparam logic [3:0] ADDR_SECOND_PULLUP = 4'h9;
	localparam logic [3:0] ADDR_CONFIG = 4'hC;
	// ==========================================
	// Field positions and widths
	localparam int FIRST_WIDTH = 6;
	localparam int SECOND_WIDTH = 8;
	localparam int REG_WIDTH = 8;
	localparam int PIN_TWO = 2;
	localparam int PIN_FOUR = 4;
	localparam int WAKEUP_BIT = 6;
	localparam int CLOCK_OUT_BIT = 7;
	localparam int CFG_IRQ_BIT = 0;
	localparam int CFG_OSC_LSB = 1;
	// ==========================================
	// Reset values
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] PULLUP_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// ==========================================
	// Oscillator options
	localparam logic [1:0] OSC_INTERNAL = 2'h0;
	localparam logic [1:0] OSC_EXTERNAL = 2'h1;
	localparam logic [1:0] OSC_RC = 2'h2;
	localparam logic [1:0] OSC_CRYSTAL = 2'h3;
endpackage
`default_nettype wire

//--- rtl/pin_sync.sv
// Two-stage synchronizer for a bank of pin levels.
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_sync_out;

	// ==========================================
	// Next values
	// The first stage feeds only the second stage, so a metastable level never fans out.
	always_comb begin
		next_stage_one = async_in;
		next_sync_out = stage_one;
		if (!rst_b) begin
			next_stage_one = '0;
			next_sync_out = '0;
		end
	end

	// Registers only.
	always_ff @(posedge ref_clk) begin
		stage_one <= next_stage_one;
		sync_out <= next_sync_out;
	end
endmodule
`default_nettype wire

//--- rtl/port_bank.sv
// One general purpose port: data latch, direction, pullup and pin read mux.
`default_nettype none
module port_bank #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register writes
	input wire logic data_we,
	input wire logic direction_we,
	input wire logic pullup_we,
	input wire logic [WIDTH-1:0] wdata,
	// Synchronized pin levels
	input wire logic [WIDTH-1:0] pin_level,
	// State
	output logic [WIDTH-1:0] data_latch,
	output logic [WIDTH-1:0] direction,
	output logic [WIDTH-1:0] pull_enable,
	output logic [WIDTH-1:0] read_value,
	output logic [WIDTH-1:0] pullup_active
);
	import gpio_pkg::*;
	logic [WIDTH-1:0] next_data_latch;
	logic [WIDTH-1:0] next_direction;
	logic [WIDTH-1:0] next_pullup;

	// ==========================================
	// Next values
	// The data latch has no reset on purpose, so its contents survive a reset.
	always_comb begin
		next_data_latch = data_latch;
		next_direction = direction;
		next_pullup = pull_enable;
		// Write always updates the data latch, whatever the direction.
		if (data_we) begin
			next_data_latch = wdata;
		end
		if (direction_we) begin
			next_direction = wdata;
		end
		if (pullup_we) begin
			next_pullup = wdata;
		end
		if (!rst_b) begin
			next_direction = DIRECTION_RESET[WIDTH-1:0];
			next_pullup = PULLUP_RESET[WIDTH-1:0];
		end
	end

	// Registers only.
	always_ff @(posedge ref_clk) begin
		data_latch <= next_data_latch;
		direction <= next_direction;
		pull_enable <= next_pullup;
	end

	// Output pins read the latch, input pins read the pin; pullup only on inputs.
	assign read_value = (direction & data_latch) | (~direction & pin_level);
	assign pullup_active = pull_enable & ~direction;
endmodule
`default_nettype wire

//--- rtl/dual_gpio_port_ab.sv
// Top of the two general purpose ports with register port and pin drivers.
//
// Overview of operation
// - First port has six pins; pin two input-only.
// - Interrupt enabled: bit two reads zero.
// - Interrupt disabled: bit two reads pin level.
// - Interrupt disabled: interrupt level test sees one.
// - Reset keeps data latches, initialises directions.
// - Read-only bit mirrors the wakeup request latch.
// - Direction one drives; reset makes all inputs.
// - First port reads latch or pin by direction.
// - Writes always update the latch.
// - First pullup needs bit set and input direction.
// - First pullup bit zero disconnects the pullup.
// - Internal/RC option: enable drives quad clock out.
// - Enable zero: pin acts as first-port pin four.
// - Second port has eight pins.
// - Reset clears second directions; one drives.
// - Second port reads latch or pin by direction.
// - Second pullup needs bit set and input.
// - Second pullup bit zero disconnects the pullup.
// - Pin two never drives, latch still stored.
`default_nettype none
module dual_gpio_port_ab (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [gpio_pkg::REG_WIDTH-1:0] wdata,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [gpio_pkg::REG_WIDTH-1:0] rdata,
	// System signals
	input wire logic wakeup_request_mirror,
	input wire logic quad_bus_clock,
	// First port pins
	input wire logic [gpio_pkg::FIRST_WIDTH-1:0] first_pin_in,
	output logic [gpio_pkg::FIRST_WIDTH-1:0] first_pin_out,
	output logic [gpio_pkg::FIRST_WIDTH-1:0] first_pin_oe_b,
	output logic [gpio_pkg::FIRST_WIDTH-1:0] first_pullup_on,
	// Second port pins
	input wire logic [gpio_pkg::SECOND_WIDTH-1:0] second_pin_in,
	output logic [gpio_pkg::SECOND_WIDTH-1:0] second_pin_out,
	output logic [gpio_pkg::SECOND_WIDTH-1:0] second_pin_oe_b,
	output logic [gpio_pkg::SECOND_WIDTH-1:0] second_pullup_on,
	// Interrupt pin level for the processor test
	output logic interrupt_pin_level
);
	import gpio_pkg::*;

	// ==========================================
	// Configuration register
	logic [REG_WIDTH-1:0] config_reg;
	logic [REG_WIDTH-1:0] next_config_reg;
	logic irq_enabled;
	logic [1:0] osc_option;
	logic clock_output_enable;
	logic clock_out_active;

	// ==========================================
	// Port state
	logic [FIRST_WIDTH-1:0] first_sync;
	logic [SECOND_WIDTH-1:0] second_sync;
	logic [FIRST_WIDTH-1:0] first_latch, first_dir, first_pull, first_read, first_pull_act;
	logic [SECOND_WIDTH-1:0] second_latch, second_dir, second_pull, second_read, second_pull_act;
	logic [REG_WIDTH-1:0] next_rdata;
	logic [REG_WIDTH-1:0] read_mux;
	logic [FIRST_WIDTH-1:0] first_drive;
	logic first_pull_we;
	logic clock_bit_we;
	logic next_clock_output_enable;

	// Address match shared by every write enable.
	function automatic logic hit(input logic [3:0] a, input logic [3:0] target, input logic strobe);
		hit = strobe && (a == target);
	endfunction

	assign first_pull_we = hit(addr, ADDR_FIRST_PULLUP, write_strobe);
	assign clock_bit_we = first_pull_we;

	// ==========================================
	// Synchronizers
	// synchronize pin levels
	pin_sync #(.WIDTH(FIRST_WIDTH)) u_first_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.async_in(first_pin_in),
		.sync_out(first_sync)
	);

	pin_sync #(.WIDTH(SECOND_WIDTH)) u_second_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.async_in(second_pin_in),
		.sync_out(second_sync)
	);

	// ==========================================
	// Port banks
	// six pin first port
	port_bank #(.WIDTH(FIRST_WIDTH)) u_first (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.data_we(hit(addr, ADDR_FIRST_DATA, write_strobe)),
		.direction_we(hit(addr, ADDR_FIRST_DIRECTION, write_strobe)),
		.pullup_we(first_pull_we),
		.wdata(wdata[FIRST_WIDTH-1:0]),
		.pin_level(first_sync),
		.data_latch(first_latch),
		.direction(first_dir),
		.pull_enable(first_pull),
		.read_value(first_read),
		.pullup_active(first_pull_act)
	);

	port_bank #(.WIDTH(SECOND_WIDTH)) u_second (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.data_we(hit(addr, ADDR_SECOND_DATA, write_strobe)),
		.direction_we(hit(addr, ADDR_SECOND_DIRECTION, write_strobe)),
		.pullup_we(hit(addr, ADDR_SECOND_PULLUP, write_strobe)),
		.wdata(wdata),
		.pin_level(second_sync),
		.data_latch(second_latch),
		.direction(second_dir),
		.pull_enable(second_pull),
		.read_value(second_read),
		.pullup_active(second_pull_act)
	);

	// ==========================================
	// Configuration and clock output enable
	// The clock output enable lives in the top bit of the first pullup register.
	always_comb begin
		next_config_reg = config_reg;
		next_clock_output_enable = clock_output_enable;
		if (hit(addr, ADDR_CONFIG, write_strobe)) begin
			next_config_reg = wdata;
		end
		if (clock_bit_we) begin
			next_clock_output_enable = wdata[CLOCK_OUT_BIT];
		end
		if (!rst_b) begin
			next_config_reg = CONFIG_RESET;
			next_clock_output_enable = 1'b0;
		end
	end

	// Registers only.
	always_ff @(posedge ref_clk) begin
		config_reg <= next_config_reg;
		clock_output_enable <= next_clock_output_enable;
	end

	assign irq_enabled = config_reg[CFG_IRQ_BIT];
	assign osc_option = config_reg[CFG_OSC_LSB+1:CFG_OSC_LSB];

	// clock out only for internal or RC
	assign clock_out_active = clock_output_enable && ((osc_option == OSC_INTERNAL) || (osc_option == OSC_RC));

	// ==========================================
	// Pin drivers
	// Enables are active low; a low enable means the pin is driven.
	always_comb begin
		first_drive = first_dir;
		first_drive[PIN_TWO] = 1'b0;
		first_pin_out = first_latch;
		first_pullup_on = first_pull_act;
		first_pullup_on[PIN_TWO] = first_pull[PIN_TWO];
		if (clock_out_active) begin
			first_drive[PIN_FOUR] = 1'b1;
			first_pin_out[PIN_FOUR] = quad_bus_clock;
			first_pullup_on[PIN_FOUR] = 1'b0;
		end
		first_pin_oe_b = ~first_drive;
	end

	assign second_pullup_on = second_pull_act;
	assign second_pin_out = second_latch;
	assign second_pin_oe_b = ~second_dir;

	// interrupt test sees one when disabled
	assign interrupt_pin_level = irq_enabled ? first_sync[PIN_TWO] : 1'b1;

	// ==========================================
	// Read path
	// Decoding by if chain; unmapped addresses read as zero.
	always_comb begin
		read_mux = ZERO_BYTE;
		if (addr == ADDR_FIRST_DATA) begin
			read_mux[FIRST_WIDTH-1:0] = first_read;
			// Pin two is input only, so it reads its pin, or zero while the interrupt is enabled.
			read_mux[PIN_TWO] = first_sync[PIN_TWO];
			if (irq_enabled) begin
				read_mux[PIN_TWO] = 1'b0;
			end
			read_mux[WAKEUP_BIT] = wakeup_request_mirror;
		end else if (addr == ADDR_SECOND_DATA) begin
			read_mux = second_read;
		end else if (addr == ADDR_FIRST_DIRECTION) begin
			read_mux[FIRST_WIDTH-1:0] = first_dir;
		end else if (addr == ADDR_SECOND_DIRECTION) begin
			read_mux = second_dir;
		end else if (addr == ADDR_FIRST_PULLUP) begin
			read_mux[FIRST_WIDTH-1:0] = first_pull;
			read_mux[CLOCK_OUT_BIT] = clock_output_enable;
		end else if (addr == ADDR_SECOND_PULLUP) begin
			read_mux = second_pull;
		end else if (addr == ADDR_CONFIG) begin
			read_mux = config_reg;
		end
	end

	// Read data stand only in the cycle after the read strobe, zero otherwise.
	always_comb begin
		next_rdata = read_strobe ? read_mux : ZERO_BYTE;
		if (!rst_b) begin
			next_rdata = ZERO_BYTE;
		end
	end

	// Registers only.
	always_ff @(posedge ref_clk) begin
		rdata <= next_rdata;
	end
endmodule
`default_nettype wire

//--- bench/pin_board.sv
// Board model that resolves each port pin from chip drive, board drive and pullup.
`default_nettype none
module pin_board #(
	parameter int WIDTH = 8
) (
	// Clock
	input wire logic ref_clk,
	// Chip side
	input wire logic [WIDTH-1:0] pin_out,
	input wire logic [WIDTH-1:0] oe_b,
	input wire logic [WIDTH-1:0] pullup_on,
	// Board drivers
	input wire logic [WIDTH-1:0] drive_en,
	input wire logic [WIDTH-1:0] drive_val,
	// Resolved levels
	output logic [WIDTH-1:0] level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [WIDTH-1:0] wobble = '0;
	// A floating pin wanders every cycle, so a stale value never matches by luck.
	always @(posedge ref_clk) begin
		wobble <= ~wobble;
	end
	// Chip drive wins, then the board driver, then the pullup.
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			level[i] = !oe_b[i] ? pin_out[i] : drive_en[i] ? drive_val[i] : pullup_on[i] ? 1'b1 : wobble[i];
		end
	end
endmodule
`default_nettype wire

//--- bench/dual_gpio_port_ab_assertions.sv
// Checker of the dual port block, bound to its top.
`default_nettype none
module dual_gpio_port_ab_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [gpio_pkg::REG_WIDTH-1:0] wdata,
	input wire logic write_strobe,
	// Pins
	input wire logic [gpio_pkg::FIRST_WIDTH-1:0] first_pin_oe_b,
	input wire logic [gpio_pkg::FIRST_WIDTH-1:0] first_pullup_on,
	input wire logic [gpio_pkg::SECOND_WIDTH-1:0] second_pin_out,
	input wire logic [gpio_pkg::SECOND_WIDTH-1:0] second_pin_oe_b,
	input wire logic [gpio_pkg::SECOND_WIDTH-1:0] second_pullup_on
);
	import gpio_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	// ==========================================
	// Drive and pullup relations.
	property p_pin_two_input;
		first_pin_oe_b[PIN_TWO];
	endproperty
	a_pin_two_input: assert property (p_pin_two_input) else $error("pin two driven");
	property p_first_pull_off;
		(first_pullup_on & ~first_pin_oe_b) == 6'h00;
	endproperty
	a_first_pull_off: assert property (p_first_pull_off) else $error("first pullup on output");
	property p_second_pull_off;
		(second_pullup_on & ~second_pin_oe_b) == 8'h00;
	endproperty
	a_second_pull_off: assert property (p_second_pull_off) else $error("second pullup on output");
	property p_reset_inputs;
		$rose(rst_b) |-> (&first_pin_oe_b) && (&second_pin_oe_b);
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) else $error("pin driven after reset");
	// ==========================================
	// Register writes and their effect on the pins.
	property p_first_dir;
		write_strobe && addr == ADDR_FIRST_DIRECTION |=> first_pin_oe_b[1:0] == ~$past(wdata[1:0]);
	endproperty
	a_first_dir: assert property (p_first_dir) else $error("first direction not applied");
	property p_second_dir;
		write_strobe && addr == ADDR_SECOND_DIRECTION |=> second_pin_oe_b == ~$past(wdata);
	endproperty
	a_second_dir: assert property (p_second_dir) else $error("second direction not applied");
	property p_second_latch;
		write_strobe && addr == ADDR_SECOND_DATA |=> second_pin_out == $past(wdata);
	endproperty
	a_second_latch: assert property (p_second_latch) else $error("second latch not written");
	property p_second_pull_zero;
		write_strobe && addr == ADDR_SECOND_PULLUP |=> (second_pullup_on & ~$past(wdata)) == 8'h00;
	endproperty
	a_second_pull_zero: assert property (p_second_pull_zero) else $error("cleared pullup still on");
endmodule
bind dual_gpio_port_ab dual_gpio_port_ab_checker i_dual_gpio_port_ab_checker (.*);
`default_nettype wire

//--- bench/dual_gpio_port_ab_tb.sv
// Self-checking bench of the dual port block.
`default_nettype none
module dual_gpio_port_ab_tb;
	import gpio_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic write_strobe = 1'b0;
	logic read_strobe = 1'b0;
	logic [7:0] rdata;
	logic wakeup_request_mirror = 1'b0;
	logic quad_bus_clock = 1'b0;
	logic [5:0] first_pin_in, first_pin_out, first_pin_oe_b, first_pullup_on;
	logic [7:0] second_pin_in, second_pin_out, second_pin_oe_b, second_pullup_on;
	logic interrupt_pin_level;
	logic [5:0] a_en = 6'h3F;
	logic [5:0] a_val = 6'h15;
	logic [7:0] b_val = 8'hA5;
	logic [7:0] got;
	int bad_count = 0;
	int compares = 0;
	always #25 ref_clk = ~ref_clk;
	always #5 quad_bus_clock = ~quad_bus_clock;
	dual_gpio_port_ab i_dual_gpio_port_ab (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.addr(addr),
		.wdata(wdata),
		.write_strobe(write_strobe),
		.read_strobe(read_strobe),
		.rdata(rdata),
		.wakeup_request_mirror(wakeup_request_mirror),
		.quad_bus_clock(quad_bus_clock),
		.first_pin_in(first_pin_in),
		.first_pin_out(first_pin_out),
		.first_pin_oe_b(first_pin_oe_b),
		.first_pullup_on(first_pullup_on),
		.second_pin_in(second_pin_in),
		.second_pin_out(second_pin_out),
		.second_pin_oe_b(second_pin_oe_b),
		.second_pullup_on(second_pullup_on),
		.interrupt_pin_level(interrupt_pin_level)
	);
	pin_board #(.WIDTH(6)) i_pin_board (.ref_clk(ref_clk), .pin_out(first_pin_out), .oe_b(first_pin_oe_b),
		.pullup_on(first_pullup_on), .drive_en(a_en), .drive_val(a_val), .level(first_pin_in));
	pin_board #(.WIDTH(8)) i_pin_board_b (.ref_clk(ref_clk), .pin_out(second_pin_out), .oe_b(second_pin_oe_b),
		.pullup_on(second_pullup_on), .drive_en(8'hFF), .drive_val(b_val), .level(second_pin_in));
	// ==========================================
	// Bus cycles, waits and comparison.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		write_strobe <= 1'b1;
		@(posedge ref_clk);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		addr <= a;
		read_strobe <= 1'b1;
		@(posedge ref_clk);
		read_strobe <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	// ==========================================
	// Scenarios.
	task automatic t_mux;
		// Latch first, then direction, so the pins never glitch.
		wr(ADDR_FIRST_DATA, 8'hCA);
		wr(ADDR_FIRST_DIRECTION, 8'h33);
		rd(ADDR_FIRST_DATA);
		chk(got, 8'h06);
		chk(8'(first_pin_oe_b), 8'h0C);
		wr(ADDR_FIRST_DIRECTION, 8'h3F);
		wakeup_request_mirror <= 1'b1;
		rd(ADDR_FIRST_DATA);
		chk(got, 8'h4E);
		chk(8'(first_pin_oe_b), 8'h04);
	endtask
	task automatic t_irq;
		wr(ADDR_FIRST_DIRECTION, 8'h00);
		wr(ADDR_CONFIG, 8'h01);
		rd(ADDR_FIRST_DATA);
		chk(got, 8'h51);
		a_val <= 6'h11;
		// One edge later the new level sits only in the first stage.
		tick(1);
		chk(8'(interrupt_pin_level), 8'h01);
		tick(2);
		chk(8'(interrupt_pin_level), 8'h00);
		wr(ADDR_CONFIG, 8'h00);
		tick(2);
		chk(8'(interrupt_pin_level), 8'h01);
		a_val <= 6'h15;
		tick(3);
		rd(ADDR_FIRST_DATA);
		chk(got, 8'h55);
	endtask
	task automatic t_pull;
		wr(ADDR_FIRST_DIRECTION, 8'h03);
		wr(ADDR_FIRST_PULLUP, 8'h3F);
		tick(1);
		chk(8'(first_pullup_on), 8'h3C);
		a_en <= 6'h00;
		tick(3);
		rd(ADDR_FIRST_DATA);
		chk(got, 8'h7E);
		wr(ADDR_FIRST_PULLUP, 8'h05);
		a_en <= 6'h3F;
		tick(1);
		chk(8'(first_pullup_on), 8'h04);
		rd(ADDR_FIRST_PULLUP);
		chk(got, 8'h05);
		wr(ADDR_SECOND_DIRECTION, 8'hF0);
		wr(ADDR_SECOND_PULLUP, 8'hFF);
		tick(1);
		chk(second_pullup_on, 8'h0F);
		wr(ADDR_SECOND_PULLUP, 8'h00);
		tick(1);
		chk(second_pullup_on, 8'h00);
	endtask
	task automatic t_second;
		wr(ADDR_SECOND_DATA, 8'h3C);
		wr(ADDR_SECOND_DIRECTION, 8'h0F);
		tick(3);
		rd(ADDR_SECOND_DATA);
		chk(got, 8'hAC);
		chk(second_pin_oe_b, 8'hF0);
	endtask
	task automatic t_clock;
		logic [7:0] cfg;
		wr(ADDR_FIRST_DIRECTION, 8'h10);
		// Every oscillator option; only internal and RC pass the clock.
		for (int m = 0; m < 4; m++) begin
			cfg = 8'(m * 2);
			wr(ADDR_CONFIG, cfg);
			wr(ADDR_FIRST_PULLUP, 8'h80);
			#2;
			for (int k = 0; k < 4; k++) begin
				#5 chk(8'(first_pin_out[PIN_FOUR]), cfg[1] ? 8'h00 : 8'(quad_bus_clock));
			end
			wr(ADDR_FIRST_PULLUP, 8'h00);
			tick(1);
			chk(8'(first_pin_out[PIN_FOUR]), 8'h00);
		end
	endtask
	task automatic t_reset;
		rst_b <= 1'b0;
		tick(4);
		rst_b <= 1'b1;
		tick(1);
		chk(8'(first_pin_oe_b), 8'h3F);
		chk(second_pin_oe_b, 8'hFF);
		rd(ADDR_SECOND_DIRECTION);
		chk(got, 8'h00);
		wr(ADDR_FIRST_DIRECTION, 8'h3F);
		wr(ADDR_SECOND_DIRECTION, 8'hFF);
		rd(ADDR_FIRST_DATA);
		chk(got, 8'h4E);
		rd(ADDR_SECOND_DATA);
		chk(got, 8'h3C);
		rd(4'hF);
		chk(got, 8'h00);
	endtask
	// ==========================================
	// Verdict.
	task automatic test_done;
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// A hung run is cut short and counted as a mismatch.
	initial begin
		#200us;
		bad_count++;
		test_done();
	end
	initial begin
		tick(4);
		rst_b <= 1'b1;
		rd(ADDR_FIRST_DIRECTION);
		chk(got, 8'h00);
		t_mux();
		t_irq();
		t_pull();
		t_second();
		t_clock();
		t_reset();
		test_done();
	end
endmodule
`default_nettype wire
